// ===== rtl/dscp_pkg.sv
// package of constants and types for the serial control pin front end
package dscp_pkg;
  // ---------------------------------------------------------------------
  // channels and data
  // ---------------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int DATA_W = 12;
  localparam int FRAME_W = 16;
  localparam int ADDR_POS = 12;
  localparam int ADDR_W = 2;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 200;
  localparam int SCLK_MAX_MHZ = 30;
  localparam int ALERT_TIMEOUT_US = 100;
  localparam int ALERT_CYCLES = ALERT_TIMEOUT_US * SYS_CLK_MHZ;
  // ---------------------------------------------------------------------
  // apb register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_FAULT_IN = 8'h10;
  localparam logic [7:0] OFS_CH_BASE = 8'h20;
  localparam logic [7:0] OFS_RDBK = 8'h30;
  // ctrl fields: clear enables [3:0], clear code select [4]
  localparam int CTRL_CLREN_POS = 0;
  localparam int CTRL_CLRCODE_POS = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // irq bit positions
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_ALERT = 2;
  localparam int IRQ_FAULT = 3;
  localparam int IRQ_W = 4;
  // fault inputs: open circuit, short, packet_check, temperature
  localparam int FAULT_W = 4;
  // output states
  typedef enum logic [1:0] {
    DSCP_OUT_TRI = 2'b00,
    DSCP_OUT_PULLDN = 2'b01,
    DSCP_OUT_ACTIVE = 2'b10
  } dscp_out_state_t;
endpackage

// ===== rtl/dscp_sync_if.sv
// interface carrying synchronised pin levels between modules
`timescale 1ns/10ps
interface dscp_sync_if;
  logic sclk;
  logic frame_n;
  logic din;
  logic load_n;
  logic clear;
  modport src (output sclk, frame_n, din, load_n, clear);
  modport dst (input sclk, frame_n, din, load_n, clear);
endinterface

// ===== rtl/dscp_pin_sync.sv
// two-stage synchronisers for the serial, load strobe and clear pins
`timescale 1ns/10ps
module dscp_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // raw pins
  input wire logic sclk_pin,
  input wire logic frame_n_pin,
  input wire logic din_pin,
  input wire logic load_n_pin,
  input wire logic clear_pin,
  // synchronised levels
  dscp_sync_if.src sy
);
  logic [4:0] meta_reg; // first stage, read only by second
  logic [4:0] stab_reg; // second stage
  // ---------------------------------------------------------------------
  // double flop; idle levels at reset so no false edges appear
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= 5'h0b;
      stab_reg <= 5'h0b;
    end else begin
      meta_reg <= {clear_pin, load_n_pin, din_pin, frame_n_pin, sclk_pin};
      stab_reg <= meta_reg;
    end
  end
  assign sy.sclk = stab_reg[0];
  assign sy.frame_n = stab_reg[1];
  assign sy.din = stab_reg[2];
  assign sy.load_n = stab_reg[3];
  assign sy.clear = stab_reg[4];
endmodule

// ===== rtl/dscp_top.sv
// serial control front end: serial port, load, clear, alert, fault, power-up state
//
// What this block does
// - accept serial bits only while frame low
// - sample serial input on sclk falling edge
// - serial clock up to 30 MHz supported
// - readback shifts apb-written readback register out on serial_out
// - load low: update output at frame rise
// - load high: input register, output on load fall
// - clear rising edge forces outputs to clear code
// - clear code lands only on clear-enabled channels
// - clear active blocks output register writes
// - alert raised after interface idle timeout
// - fault low on any detected fault condition
// - sample power-up select after every reset
// - select 0: all outputs high impedance
// - select 1: voltage pull-down, current high impedance
// - active-low hardware reset returns reset state
`timescale 1ns/10ps
module dscp_top
  import dscp_pkg::*;
#(
  parameter int ALERT_CNT = ALERT_CYCLES
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial port pins
  input wire logic SCLK,
  input wire logic FRAME_N,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  // control pins
  input wire logic OUTPUT_LOAD_STROBE_N,
  input wire logic CLEAR,
  input wire logic POWER_UP_STATE_SELECT,
  input wire logic RESET_N,
  input wire logic [FAULT_W-1:0] FAULT_SRC,
  // status pins
  output logic ALERT,
  output logic FAULT_N_O,
  output logic FAULT_N_OE,
  output logic IRQ,
  // channel outputs
  output logic [NUM_CH*DATA_W-1:0] CH_CODE,
  output logic [NUM_CH*2-1:0] CH_VSTATE,
  output logic [NUM_CH*2-1:0] CH_ISTATE
);
  // ---------------------------------------------------------------------
  // synchronisation of pins
  // ---------------------------------------------------------------------
  dscp_sync_if sy ();
  logic rstn_m_reg; // reset pin first stage
  logic rstn_s_reg; // reset pin second stage
  logic [FAULT_W-1:0] flt_m_reg; // fault inputs first stage
  logic [FAULT_W-1:0] flt_s_reg; // fault inputs second stage
  logic pup_m_reg; // select pin first stage
  logic pup_s_reg; // select pin second stage
  dscp_pin_sync dscp_pin_sync_i (
    .clk(CLK_SYS),
    .srst(SRST),
    .sclk_pin(SCLK),
    .frame_n_pin(FRAME_N),
    .din_pin(SERIAL_IN),
    .load_n_pin(OUTPUT_LOAD_STROBE_N),
    .clear_pin(CLEAR),
    .sy(sy)
  );
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rstn_m_reg <= 1'b0;
      rstn_s_reg <= 1'b0;
      flt_m_reg <= '0;
      flt_s_reg <= '0;
      pup_m_reg <= 1'b0;
      pup_s_reg <= 1'b0;
    end else begin
      rstn_m_reg <= RESET_N;
      rstn_s_reg <= rstn_m_reg;
      flt_m_reg <= FAULT_SRC;
      flt_s_reg <= flt_m_reg;
      pup_m_reg <= POWER_UP_STATE_SELECT;
      pup_s_reg <= pup_m_reg;
    end
  end
  // device reset: system reset or hardware pin low
  logic dev_rst;
  assign dev_rst = SRST | ~rstn_s_reg;
  // ---------------------------------------------------------------------
  // edge detection on synchronised levels
  // ---------------------------------------------------------------------
  logic sclk_d_reg, frame_d_reg, load_d_reg, clear_d_reg;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      sclk_d_reg <= 1'b1;
      frame_d_reg <= 1'b1;
      load_d_reg <= 1'b1;
      clear_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sy.sclk;
      frame_d_reg <= sy.frame_n;
      load_d_reg <= sy.load_n;
      clear_d_reg <= sy.clear;
    end
  end
  logic sclk_fall, sclk_rise, frame_rise, load_fall, clear_rise;
  // 200 MHz sampling leaves over 3 samples per half period at 30 MHz
  assign sclk_fall = sclk_d_reg & ~sy.sclk;
  assign sclk_rise = ~sclk_d_reg & sy.sclk;
  assign frame_rise = ~frame_d_reg & sy.frame_n;
  assign load_fall = load_d_reg & ~sy.load_n;
  assign clear_rise = ~clear_d_reg & sy.clear;
  // ---------------------------------------------------------------------
  // serial shift register
  // ---------------------------------------------------------------------
  logic [FRAME_W-1:0] shift_reg; // incoming frame
  logic [4:0] bitcnt_reg; // bits taken in this frame
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      shift_reg <= '0;
      bitcnt_reg <= 5'h00;
    end else if (sy.frame_n) begin
      bitcnt_reg <= 5'h00; // idle between frames
    end else if (sclk_fall) begin
      // bits are only taken while the frame is low
      shift_reg <= {shift_reg[FRAME_W-2:0], sy.din};
      if (bitcnt_reg != 5'h11) begin // saturate past 16 so long frames fail too
        bitcnt_reg <= bitcnt_reg + 5'h01;
      end
    end
  end
  logic frame_ok;
  // short or long frames are discarded at the frame end
  assign frame_ok = frame_rise && (bitcnt_reg == 5'h10);
  logic [ADDR_W-1:0] wr_ch;
  assign wr_ch = shift_reg[ADDR_POS+ADDR_W-1:ADDR_POS];
  // ---------------------------------------------------------------------
  // readback: shifts out on rising edge so host samples at falling
  // ---------------------------------------------------------------------
  logic [FRAME_W-1:0] rdbk_reg; // word queued for readback
  logic [FRAME_W-1:0] out_sh_reg; // outgoing shifter
  logic sout_reg;
  logic frame_fall;
  assign frame_fall = frame_d_reg & ~sy.frame_n;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      out_sh_reg <= '0;
      sout_reg <= 1'b0;
    end else if (frame_fall) begin
      out_sh_reg <= {rdbk_reg[FRAME_W-2:0], 1'b0};
      sout_reg <= rdbk_reg[FRAME_W-1];
    end else if (!sy.frame_n && sclk_rise) begin
      sout_reg <= out_sh_reg[FRAME_W-1];
      out_sh_reg <= {out_sh_reg[FRAME_W-2:0], 1'b0};
    end
  end
  // ---------------------------------------------------------------------
  // apb control registers
  // ---------------------------------------------------------------------
  logic [4:0] ctrl_reg; // clear enables and clear code select
  logic [IRQ_W-1:0] irq_stat_reg; // sticky events
  logic [IRQ_W-1:0] irq_mask_reg; // enable per event
  logic apb_wr, apb_rd;
  assign apb_wr = PSEL & PENABLE & PWRITE;
  assign apb_rd = PSEL & PENABLE & ~PWRITE;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= '0;
      rdbk_reg <= '0;
    end else if (apb_wr) begin
      if (PADDR == OFS_CTRL) begin
        ctrl_reg <= PWDATA[4:0];
      end
      if (PADDR == OFS_IRQ_MASK) begin
        irq_mask_reg <= PWDATA[IRQ_W-1:0];
      end
      if (PADDR == OFS_RDBK) begin
        rdbk_reg <= PWDATA[FRAME_W-1:0];
      end
    end
  end
  // ---------------------------------------------------------------------
  // channel input and output registers
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] in_reg [NUM_CH]; // channel input registers
  logic [DATA_W-1:0] out_reg [NUM_CH]; // channel output registers
  logic [NUM_CH-1:0] pend_reg; // input loaded, awaiting load strobe
  logic [DATA_W-1:0] clr_code;
  assign clr_code = ctrl_reg[CTRL_CLRCODE_POS] ? {DATA_W{1'b1}} : '0;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_reg[i] <= '0;
        out_reg[i] <= '0;
      end
      pend_reg <= '0;
    end else begin
      if (frame_ok) begin
        in_reg[wr_ch] <= shift_reg[DATA_W-1:0];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (clear_rise && ctrl_reg[CTRL_CLREN_POS+i]) begin
          out_reg[i] <= clr_code;
          pend_reg[i] <= 1'b0;
        end else if (sy.clear) begin
          // outputs frozen while clear is high
          pend_reg[i] <= pend_reg[i];
        end else if (frame_ok && wr_ch == i[ADDR_W-1:0] && !sy.load_n) begin
          out_reg[i] <= shift_reg[DATA_W-1:0];
        end else if (load_fall && pend_reg[i]) begin
          out_reg[i] <= in_reg[i];
          pend_reg[i] <= 1'b0;
        end else if (frame_ok && wr_ch == i[ADDR_W-1:0]) begin
          pend_reg[i] <= 1'b1;
        end
      end
    end
  end
  // ---------------------------------------------------------------------
  // power-up state, caught after each reset release
  // ---------------------------------------------------------------------
  dscp_out_state_t vst_reg; // voltage output state
  logic vst_taken_reg; // select pin caught since reset
  logic any_load;
  assign any_load = frame_ok | load_fall;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      vst_reg <= DSCP_OUT_TRI;
      vst_taken_reg <= 1'b0;
    end else if (!vst_taken_reg) begin
      vst_taken_reg <= 1'b1;
      vst_reg <= pup_s_reg ? DSCP_OUT_PULLDN : DSCP_OUT_TRI;
    end else if (any_load) begin
      vst_reg <= DSCP_OUT_ACTIVE;
    end
  end
  // current outputs stay tristate until first load either way
  logic ist_active_reg;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      ist_active_reg <= 1'b0;
    end else if (vst_taken_reg && any_load) begin
      ist_active_reg <= 1'b1;
    end
  end
  // ---------------------------------------------------------------------
  // idle timer and alert
  // ---------------------------------------------------------------------
  logic [31:0] idle_cnt_reg;
  logic alert_reg;
  logic activity;
  assign activity = sclk_fall | sclk_rise | frame_fall | frame_rise;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      idle_cnt_reg <= '0;
      alert_reg <= 1'b0;
    end else if (activity) begin
      idle_cnt_reg <= '0;
      alert_reg <= 1'b0;
    end else if (idle_cnt_reg == 32'(ALERT_CNT - 1)) begin
      alert_reg <= 1'b1;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 32'h1;
    end
  end
  // ---------------------------------------------------------------------
  // fault flag, interrupts and apb read
  // ---------------------------------------------------------------------
  logic fault_any;
  assign fault_any = |flt_s_reg;
  logic alert_rise_d;
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      alert_rise_d <= 1'b0;
    end else begin
      alert_rise_d <= alert_reg;
    end
  end
  logic [IRQ_W-1:0] ev;
  assign ev = {fault_any, alert_reg & ~alert_rise_d, clear_rise, frame_ok};
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      irq_stat_reg <= '0;
    end else begin
      // a new event wins over a same-cycle clear
      irq_stat_reg <= (irq_stat_reg & ~((apb_wr && PADDR == OFS_IRQ_STAT) ? PWDATA[IRQ_W-1:0] : '0)) | ev;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (dev_rst) begin
      FAULT_N_O <= 1'b0;
      FAULT_N_OE <= 1'b0;
      IRQ <= 1'b0;
      ALERT <= 1'b0;
      SERIAL_OUT <= 1'b0;
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      CH_CODE <= '0;
      CH_VSTATE <= '0;
      CH_ISTATE <= '0;
    end else begin
      FAULT_N_OE <= fault_any;
      IRQ <= |(irq_stat_reg & irq_mask_reg);
      ALERT <= alert_reg;
      SERIAL_OUT <= sout_reg;
      for (int i = 0; i < NUM_CH; i++) begin
        CH_CODE[i*DATA_W +: DATA_W] <= out_reg[i];
        CH_VSTATE[i*2 +: 2] <= vst_reg;
        CH_ISTATE[i*2 +: 2] <= ist_active_reg ? DSCP_OUT_ACTIVE : DSCP_OUT_TRI;
      end
      // no wait state: ready in the first access cycle, dropped after
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          OFS_CTRL: PRDATA <= {27'h0, ctrl_reg};
          OFS_STATUS: PRDATA <= {26'h0, ist_active_reg, vst_reg, sy.clear, alert_reg, fault_any};
          OFS_IRQ_STAT: PRDATA <= {28'h0, irq_stat_reg};
          OFS_IRQ_MASK: PRDATA <= {28'h0, irq_mask_reg};
          OFS_FAULT_IN: PRDATA <= {28'h0, flt_s_reg};
          OFS_RDBK: PRDATA <= {16'h0, rdbk_reg};
          default: begin
            if (PADDR[7:4] == OFS_CH_BASE[7:4] && PADDR[1:0] == 2'b00) begin
              PRDATA <= {20'h0, out_reg[PADDR[3:2]]};
            end else begin
              PRDATA <= '0;
            end
          end
        endcase
      end
    end
  end
  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  AST_NO_SHIFT_IDLE: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    sy.frame_n |=> $stable(shift_reg)) else $error("shift moved with frame high");
  AST_SHIFT_FALL: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (!sy.frame_n && sclk_fall) |=> shift_reg[0] == $past(sy.din)) else $error("bit not taken");
  AST_LOAD_LOW: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (frame_ok && !sy.load_n && !sy.clear) |=> out_reg[$past(wr_ch)] == $past(shift_reg[DATA_W-1:0]))
    else $error("direct update missing");
  AST_LOAD_HIGH: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (frame_ok && sy.load_n && !sy.clear && !load_fall) |=> pend_reg[$past(wr_ch)])
    else $error("pending not set");
  AST_CLEAR: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (clear_rise && ctrl_reg[0]) |=> out_reg[0] == $past(clr_code)) else $error("clear failed");
  AST_CLEAR_KEEP: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (clear_rise && !ctrl_reg[1] && !frame_ok && !load_fall) |=> $stable(out_reg[1]))
    else $error("disabled channel cleared");
  AST_CLEAR_BLOCK: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (sy.clear && !clear_rise) |=> $stable(out_reg[2])) else $error("write during clear");
  AST_ALERT_DROP: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    activity |=> !alert_reg ##1 !ALERT) else $error("alert held over activity");
  AST_ALERT_SET: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (idle_cnt_reg == 32'(ALERT_CNT - 1) && !activity) |=> alert_reg) else $error("alert late");
  AST_FAULT: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    fault_any |=> FAULT_N_OE && !FAULT_N_O) else $error("fault not driven");
  AST_PUP_SEL: assert property (@(posedge CLK_SYS) disable iff (dev_rst)
    (!vst_taken_reg && pup_s_reg) |=> vst_reg == DSCP_OUT_PULLDN) else $error("select ignored");
  AST_RESET_PIN: assert property (@(posedge CLK_SYS)
    (!SRST && !rstn_s_reg) |=> ctrl_reg == CTRL_RESET) else $error("pin reset ignored");
  COV_FRAME: cover property (@(posedge CLK_SYS) frame_ok);
  COV_LOAD: cover property (@(posedge CLK_SYS) load_fall && |pend_reg);
  COV_CLEAR: cover property (@(posedge CLK_SYS) clear_rise);
  COV_ALERT: cover property (@(posedge CLK_SYS) alert_reg && !alert_rise_d);
endmodule

// ===== testbench/dscp_host.sv
// host controller model that drives the serial port of the front end
`timescale 1ns/10ps
module dscp_host (
  // serial port towards the device
  output logic sclk,
  output logic frame_n,
  output logic din,
  // readback from the device
  input wire logic dout
);
  // ---------------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------------
  // clock parks high, frame inactive, data low
  initial begin
    sclk = 1'b1;
    frame_n = 1'b1;
    din = 1'b0;
  end

  // ---------------------------------------------------------------------
  // one frame, msb first, readback captured on each falling edge
  // ---------------------------------------------------------------------
  // 64 ns clock period, well inside the serial clock ceiling
  task automatic frame(input logic [15:0] w, input int nbits, output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    // small offset keeps the link unrelated in phase to the system clock
    #3;
    frame_n = 1'b0; // bits only count while frame is low
    for (i = 0; i < nbits; i++) begin
      // data set half a period before the falling edge
      din = w[15-i];
      #32;
      sclk = 1'b0;
      rd[15-i] = dout;
      #32;
      sclk = 1'b1;
    end
    #32;
    frame_n = 1'b1;
    // released data line must not keep showing the last bit
    din = ~din;
    #64;
  endtask
endmodule

// ===== testbench/dscp_top_tb.sv
// self-checking bench for the serial control front end
`timescale 1ns/10ps
module dscp_top_tb;
  import dscp_pkg::*;
  // ---------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------
  logic clk_sys, srst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, serial_out, load_n, clear, pup_sel, reset_n;
  logic [FAULT_W-1:0] fault_src;
  logic alert, fault_o, fault_oe, irq;
  logic [NUM_CH*DATA_W-1:0] ch_code;
  logic [NUM_CH*2-1:0] ch_vstate, ch_istate;
  logic [15:0] rd;
  wire sclk, frame_n, serial_in;
  // open-drain fault line with its pull-up
  wire fault_line = fault_oe ? fault_o : 1'b1;
  int miscompares, n_checks, i;

  // ---------------------------------------------------------------------
  // clock, device and host
  // ---------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // short idle timeout keeps the alert scenario brief
  dscp_top #(.ALERT_CNT(50)) dscp_top_i (
    .CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCLK(sclk), .FRAME_N(frame_n), .SERIAL_IN(serial_in), .SERIAL_OUT(serial_out),
    .OUTPUT_LOAD_STROBE_N(load_n), .CLEAR(clear), .POWER_UP_STATE_SELECT(pup_sel),
    .RESET_N(reset_n), .FAULT_SRC(fault_src), .ALERT(alert), .FAULT_N_O(fault_o),
    .FAULT_N_OE(fault_oe), .IRQ(irq), .CH_CODE(ch_code), .CH_VSTATE(ch_vstate),
    .CH_ISTATE(ch_istate));

  dscp_host dscp_host_i (.sclk(sclk), .frame_n(frame_n), .din(serial_in), .dout(serial_out));

  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  // compare seen against expected and count
  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    // a lost answer counts as a mismatch
    if (n >= 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // printing the verdict and ending the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // watchdog, far beyond the expected run of some 5 us
  // ---------------------------------------------------------------------
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    miscompares = 0;
    n_checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {load_n, clear, pup_sel, reset_n, fault_src} = {1'b0, 1'b0, 1'b0, 1'b1, 4'h0};
    srst = 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    // power-up select low: everything high impedance
    chk("vstate sel0", ch_vstate, 8'h00);
    chk("istate sel0", ch_istate, 8'h00);
    // hardware reset with select high picks voltage pull-down
    pup_sel <= 1'b1;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("vstate sel1", ch_vstate, 8'h55);
    chk("istate sel1", ch_istate, 8'h00);
    chk("code after reset", ch_code, 48'h0);
    // idle beyond the timeout raises alert
    repeat (60) @(posedge clk_sys);
    chk("alert idle", alert, 1'b1);
    // readback word shifts out while a write lands on channel 2
    apb(OFS_RDBK, 1'b1, 32'ha5c3a5c3, rdv);
    dscp_host_i.frame(16'h2abc, 16, rd);
    chk("alert after frame", alert, 1'b0);
    repeat (10) @(posedge clk_sys);
    chk("readback", rd, 16'ha5c3);
    chk("ch2 load low", ch_code[24 +: 12], 12'habc);
    chk("istate active", ch_istate, 8'haa);
    // frame interrupt: status, mask, write-one clear
    apb(OFS_IRQ_STAT, 1'b0, 32'h0, rdv);
    chk("frame irq stat", rdv[IRQ_FRAME], 1'b1);
    apb(OFS_IRQ_MASK, 1'b1, 32'h1, rdv);
    repeat (3) @(posedge clk_sys);
    chk("irq masked in", irq, 1'b1);
    apb(OFS_IRQ_STAT, 1'b1, 32'h1, rdv);
    repeat (3) @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    // a short frame is thrown away
    dscp_host_i.frame(16'h0777, 8, rd);
    repeat (10) @(posedge clk_sys);
    chk("short frame", ch_code[0 +: 12], 12'h000);
    // load held high: output waits for the strobe's falling edge
    load_n <= 1'b1;
    dscp_host_i.frame(16'h1123, 16, rd);
    repeat (10) @(posedge clk_sys);
    chk("ch1 held", ch_code[12 +: 12], 12'h000);
    load_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("ch1 loaded", ch_code[12 +: 12], 12'h123);
    // clear enabled on channels 0 and 2, full-scale clear code
    apb(OFS_CTRL, 1'b1, 32'h15, rdv);
    clear <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("ch0 cleared", ch_code[0 +: 12], 12'hfff);
    chk("ch2 cleared", ch_code[24 +: 12], 12'hfff);
    chk("ch1 kept", ch_code[12 +: 12], 12'h123);
    // writes blocked while clear stays high
    dscp_host_i.frame(16'h3456, 16, rd);
    repeat (10) @(posedge clk_sys);
    chk("ch3 blocked", ch_code[36 +: 12], 12'h000);
    clear <= 1'b0;
    // each fault source pulls the open-drain line low
    for (i = 0; i < FAULT_W; i++) begin
      fault_src <= 4'h1 << i;
      repeat (6) @(posedge clk_sys);
      chk("fault line", fault_line, 1'b0);
    end
    fault_src <= 4'h0;
    repeat (6) @(posedge clk_sys);
    chk("fault released", fault_line, 1'b1);
    // unmapped address reads zero without error
    apb(8'hfc, 1'b0, 32'h0, rdv);
    chk("unmapped", rdv, 32'h0);
    chk("slverr", pslverr, 1'b0);
    // zero clear code, channel 1 enabled only
    apb(OFS_CTRL, 1'b1, 32'h02, rdv);
    clear <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("ch1 zero clear", ch_code[12 +: 12], 12'h000);
    chk("ch0 not cleared", ch_code[0 +: 12], 12'hfff);
    clear <= 1'b0;
    // second hardware reset in mid-run, select still high
    reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("vstate after pin reset", ch_vstate, 8'h55);
    chk("code after pin reset", ch_code, 48'h0);
    apb(OFS_CTRL, 1'b0, 32'h0, rdv);
    chk("ctrl after pin reset", rdv, 32'h0);
    stop_test();
  end
endmodule
